// ==== logic/sicond_pkg.sv ====
// Constants shared by the sync input conditioning logic.
// Contract
// - Line sync leading edge is the pixel clock reference and line origin.
// - Line sync polarity is auto-detected or forced by a control field.
// - Polarity 0 makes the falling edge active; polarity 1 the rising edge.
// - Clock reference uses the leading edge only; clamp uses trailing edge.
// - Frame sync polarity is auto-detected or forced by a control field.
// - Field parity and internal coast come from polarity-corrected frame sync, or from composite broad pulses with slicer line source.
// - Slicer threshold steps 8 mV from 8 to 256 mV, reset value 128 mV.
// - Slicer result goes to the slicer output pin without inversion.
// - Line component is separated from slicer composite sync first.
// - Without external clamp: delay, then width, after trailing edge.
package sicond_pkg;

    // Control register offsets holding the polarity fields
    localparam logic [7:0] LINE_POL_REG = 8'h12;
    localparam logic [7:0] FRAME_POL_REG = 8'h14;
    // Field layout inside the two-bit polarity control (register bits 5:4)
    localparam int POL_FIELD_LSB = 4;
    localparam int POL_FORCE_BIT = 1;
    localparam int POL_VALUE_BIT = 0;
    localparam logic [1:0] POL_FIELD_RESET = 2'h0;

    // Slicer threshold in millivolts
    localparam int SLICE_STEP_MV = 8;
    localparam int SLICE_MIN_MV = 8;
    localparam int SLICE_MAX_MV = 256;
    localparam int SLICE_RESET_MV = 128;
    localparam int SLICE_CODE_W = 5;
    localparam logic [SLICE_CODE_W-1:0] SLICE_RESET_CODE =
        SLICE_CODE_W'((SLICE_RESET_MV - SLICE_MIN_MV) / SLICE_STEP_MV);

    // Input set selection
    localparam logic SET_A = 1'b0;
    localparam logic SET_B = 1'b1;

    // Line source: dedicated pin or composite from the slicer
    localparam logic LINE_SRC_PIN = 1'b0;
    localparam logic LINE_SRC_SLICER = 1'b1;

    // Clamp sequencer states
    typedef enum logic [1:0] {
        SICOND_CLAMP_IDLE,
        SICOND_CLAMP_DELAY,
        SICOND_CLAMP_HOLD
    } sicond_clamp_e;

endpackage : sicond_pkg

// ==== logic/sicond_pol_detect.sv ====
// Automatic sync polarity detector: the shorter phase is the pulse.
module sicond_pol_detect #(
    parameter int CNT_W = 16
) (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic sync_i,
    output logic active_high_o
);

    initial begin
        if (CNT_W < 2) begin
            $error("sicond_pol_detect: CNT_W too small");
        end
    end

    logic sync_prev_q;
    logic [CNT_W-1:0] high_cnt_q;
    logic [CNT_W-1:0] low_cnt_q;
    logic active_high_q;
    logic rise;

    assign rise = sync_i & ~sync_prev_q;
    assign active_high_o = active_high_q;

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            sync_prev_q <= 1'b0;
        end else begin
            sync_prev_q <= sync_i;
        end
    end

    // Saturating phase counters, restarted at every rising edge
    always_ff @(posedge sys_clk_i) begin
        if (reset_i || rise) begin
            high_cnt_q <= '0;
            low_cnt_q <= '0;
        end else if (sync_i) begin
            if (~&high_cnt_q) begin
                high_cnt_q <= high_cnt_q + 1'b1;
            end
        end else if (~&low_cnt_q) begin
            low_cnt_q <= low_cnt_q + 1'b1;
        end
    end

    // Decide once per period; a high pulse shorter than the gap means high
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            active_high_q <= 1'b0;
        end else if (rise && (high_cnt_q != '0 || low_cnt_q != '0)) begin
            active_high_q <= (high_cnt_q < low_cnt_q);
        end
    end

endmodule : sicond_pol_detect

// ==== logic/sicond_top.sv ====
// Sync input conditioning: select, polarity, edges, field, coast, clamp.
module sicond_top #(
    parameter int LINE_CNT_W = 16,
    parameter int FRAME_CNT_W = 24,
    parameter int CLAMP_W = 8,
    parameter int COAST_W = 8,
    parameter int LINE_HOLDOFF = 512,
    parameter int BROAD_PULSE = 256
) (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic line_sync_in_a_i,
    input wire logic line_sync_in_b_i,
    input wire logic frame_sync_in_a_i,
    input wire logic frame_sync_in_b_i,
    input wire logic green_embedded_sync_in_a_i,
    input wire logic green_embedded_sync_in_b_i,
    input wire logic ext_clamp_i,
    input wire logic input_set_sel_i,
    input wire logic line_src_sel_i,
    input wire logic [1:0] line_pol_ctrl_i,
    input wire logic [1:0] frame_pol_ctrl_i,
    input wire logic [sicond_pkg::SLICE_CODE_W-1:0] slice_code_i,
    input wire logic slice_code_wr_i,
    input wire logic ext_clamp_en_i,
    input wire logic [CLAMP_W-1:0] clamp_delay_i,
    input wire logic [CLAMP_W-1:0] clamp_width_i,
    input wire logic [COAST_W-1:0] coast_post_lines_i,
    output logic line_ref_pulse_o,
    output logic line_trail_pulse_o,
    output logic line_sync_o,
    output logic frame_sync_o,
    output logic line_pol_o,
    output logic frame_pol_o,
    output logic field_odd_o,
    output logic coast_o,
    output logic clamp_o,
    output logic slicer_sync_out_o,
    output logic [sicond_pkg::SLICE_CODE_W-1:0] slice_code_o
);

    initial begin
        if (LINE_HOLDOFF >= (1 << LINE_CNT_W) ||
            BROAD_PULSE >= (1 << LINE_CNT_W) ||
            CLAMP_W < 1 || COAST_W < 1 || FRAME_CNT_W < 2) begin
            $error("sicond_top: parameters out of range");
        end
    end

    localparam logic [LINE_CNT_W-1:0] HOLDOFF_CNT = LINE_CNT_W'(LINE_HOLDOFF);
    localparam logic [LINE_CNT_W-1:0] BROAD_CNT = LINE_CNT_W'(BROAD_PULSE);

    // Effective polarity: forced value or detected value
    function automatic logic pick_pol(input logic [1:0] ctrl,
                                      input logic detected);
        pick_pol = ctrl[sicond_pkg::POL_FORCE_BIT] ?
                   ctrl[sicond_pkg::POL_VALUE_BIT] : detected;
    endfunction : pick_pol

    // two-stage synchronisers
    // Pins are asynchronous; only stage two is read by any logic
    logic [6:0] pin_meta_q;
    logic [6:0] pin_sync_q;
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            pin_meta_q <= '0;
            pin_sync_q <= '0;
        end else begin
            pin_meta_q <= {ext_clamp_i, green_embedded_sync_in_b_i,
                           green_embedded_sync_in_a_i, frame_sync_in_b_i,
                           frame_sync_in_a_i, line_sync_in_b_i,
                           line_sync_in_a_i};
            pin_sync_q <= pin_meta_q;
        end
    end

    logic line_raw;
    logic frame_raw;
    logic slicer_raw;
    assign line_raw = (input_set_sel_i == sicond_pkg::SET_B) ?
                      pin_sync_q[1] : pin_sync_q[0];
    assign frame_raw = (input_set_sel_i == sicond_pkg::SET_B) ?
                       pin_sync_q[3] : pin_sync_q[2];
    assign slicer_raw = (input_set_sel_i == sicond_pkg::SET_B) ?
                        pin_sync_q[5] : pin_sync_q[4];

    // slicer result out, same sense as the embedded sync
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            slicer_sync_out_o <= 1'b0;
        end else begin
            slicer_sync_out_o <= slicer_raw;
        end
    end

    // slicer threshold code, mV = 8 * (code + 1)
    // Every 5-bit code is legal, so no clipping is needed
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            slice_code_o <= sicond_pkg::SLICE_RESET_CODE;
        end else if (slice_code_wr_i) begin
            slice_code_o <= slice_code_i;
        end
    end

    // composite separation: broad pulses mark the frame interval
    // and leading edges inside the hold-off (half-line pulses) are dropped
    logic comp_prev_q;
    logic [LINE_CNT_W-1:0] comp_gap_q;
    logic [LINE_CNT_W-1:0] comp_wide_q;
    logic comp_line_q;
    logic comp_frame_q;
    logic line_pol_det;
    logic line_pol;
    logic comp_act;
    logic comp_lead;
    assign line_pol = pick_pol(line_pol_ctrl_i, line_pol_det);
    assign comp_act = slicer_raw ~^ line_pol;
    assign comp_lead = comp_act & ~comp_prev_q;

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            comp_prev_q <= 1'b0;
            comp_gap_q <= '0;
            comp_wide_q <= '0;
            comp_line_q <= 1'b0;
            comp_frame_q <= 1'b0;
        end else begin
            comp_prev_q <= comp_act;
            if (comp_lead && comp_gap_q >= HOLDOFF_CNT) begin
                comp_gap_q <= '0;
                comp_line_q <= 1'b1;
            end else begin
                if (~&comp_gap_q) begin
                    comp_gap_q <= comp_gap_q + 1'b1;
                end
                if (!comp_act) begin
                    comp_line_q <= 1'b0;
                end
            end
            if (!comp_act) begin
                comp_wide_q <= '0;
            end else if (~&comp_wide_q) begin
                comp_wide_q <= comp_wide_q + 1'b1;
            end
            if (comp_wide_q >= BROAD_CNT) begin
                comp_frame_q <= 1'b1;
            end else if (comp_lead && comp_gap_q >= HOLDOFF_CNT) begin
                comp_frame_q <= 1'b0;
            end
        end
    end

    // line polarity detection on the selected pin, also when the slicer is the line source
    logic frame_pol_det;
    sicond_pol_detect #(.CNT_W(LINE_CNT_W)) u_line_pol (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .sync_i(line_raw),
        .active_high_o(line_pol_det)
    );

    // frame polarity detection on the selected pin
    sicond_pol_detect #(.CNT_W(FRAME_CNT_W)) u_frame_pol (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .sync_i(frame_raw),
        .active_high_o(frame_pol_det)
    );

    // correct polarity so that active reads as one
    logic frame_pol, line_act, frame_act;
    assign frame_pol = pick_pol(frame_pol_ctrl_i, frame_pol_det);
    assign line_act = (line_src_sel_i == sicond_pkg::LINE_SRC_SLICER) ?
                      comp_line_q : (line_raw ~^ line_pol);
    assign frame_act = (line_src_sel_i == sicond_pkg::LINE_SRC_SLICER) ?
                       comp_frame_q : (frame_raw ~^ frame_pol);

    // leading edge to the clock reference, trailing edge to clamp
    logic line_prev_q, frame_prev_q;
    logic line_lead, line_trail, frame_lead;
    assign line_lead = line_act & ~line_prev_q;
    assign line_trail = ~line_act & line_prev_q;
    assign frame_lead = frame_act & ~frame_prev_q;

    // line reference pulse and corrected levels
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            line_prev_q <= 1'b0;
            frame_prev_q <= 1'b0;
            line_ref_pulse_o <= 1'b0;
            line_trail_pulse_o <= 1'b0;
            line_sync_o <= 1'b0;
            frame_sync_o <= 1'b0;
            line_pol_o <= 1'b0;
            frame_pol_o <= 1'b0;
        end else begin
            line_prev_q <= line_act;
            frame_prev_q <= frame_act;
            line_ref_pulse_o <= line_lead;
            line_trail_pulse_o <= line_trail;
            line_sync_o <= line_act;
            frame_sync_o <= frame_act;
            line_pol_o <= line_pol;
            frame_pol_o <= frame_pol;
        end
    end

    // field parity: frame edge in the first half of a line is odd
    logic [LINE_CNT_W-1:0] line_pos_q;
    logic [LINE_CNT_W-1:0] line_len_q;
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            line_pos_q <= '0;
            line_len_q <= '0;
            field_odd_o <= 1'b0;
        end else begin
            if (line_lead) begin
                line_pos_q <= '0;
                line_len_q <= line_pos_q;
            end else if (~&line_pos_q) begin
                line_pos_q <= line_pos_q + 1'b1;
            end
            if (frame_lead) begin
                field_odd_o <= line_lead || (line_pos_q < (line_len_q >> 1));
            end
        end
    end

    // internal coast: frame pulse plus a programmed run of lines
    // so equalising pulses never disturb the clock reference
    logic [COAST_W-1:0] coast_left_q;
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            coast_left_q <= '0;
            coast_o <= 1'b0;
        end else begin
            if (frame_act) begin
                coast_left_q <= coast_post_lines_i;
            end else if (line_lead && coast_left_q != '0) begin
                coast_left_q <= coast_left_q - 1'b1;
            end
            coast_o <= frame_act || (coast_left_q != '0);
        end
    end

    // internal clamp: delay then width, counted from trailing edge
    sicond_pkg::sicond_clamp_e clamp_state_q;
    logic [CLAMP_W-1:0] clamp_cnt_q;
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            clamp_state_q <= sicond_pkg::SICOND_CLAMP_IDLE;
            clamp_cnt_q <= '0;
        end else begin
            case (clamp_state_q)
                sicond_pkg::SICOND_CLAMP_IDLE: begin
                    if (line_trail) begin
                        clamp_cnt_q <= clamp_delay_i;
                        clamp_state_q <= sicond_pkg::SICOND_CLAMP_DELAY;
                    end
                end
                sicond_pkg::SICOND_CLAMP_DELAY: begin
                    if (clamp_cnt_q == '0) begin
                        clamp_cnt_q <= clamp_width_i;
                        clamp_state_q <= (clamp_width_i == '0) ?
                            sicond_pkg::SICOND_CLAMP_IDLE :
                            sicond_pkg::SICOND_CLAMP_HOLD;
                    end else begin
                        clamp_cnt_q <= clamp_cnt_q - 1'b1;
                    end
                end
                sicond_pkg::SICOND_CLAMP_HOLD: begin
                    if (clamp_cnt_q <= CLAMP_W'(1)) begin
                        clamp_state_q <= sicond_pkg::SICOND_CLAMP_IDLE;
                    end
                    clamp_cnt_q <= clamp_cnt_q - 1'b1;
                end
                default: begin
                    clamp_state_q <= sicond_pkg::SICOND_CLAMP_IDLE;
                end
            endcase
        end
    end

    // external clamp pin wins only when enabled
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            clamp_o <= 1'b0;
        end else if (ext_clamp_en_i) begin
            clamp_o <= pin_sync_q[6];
        end else begin
            clamp_o <= (clamp_state_q == sicond_pkg::SICOND_CLAMP_HOLD);
        end
    end

endmodule : sicond_top

// ==== verification/sicond_src_model.sv ====
// Behavioural video source driving line and frame sync of one input set.
module sicond_src_model #(
    parameter int PER = 40,
    parameter int WID = 4
) (
    input wire logic clk_i,
    input wire logic run_i,
    input wire logic pol_i,
    output logic line_o,
    output logic frame_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int cyc;
    int lines;

    // Line and frame counters; stopping rewinds so every burst starts alike
    always_ff @(posedge clk_i) begin
        if (!run_i) begin
            cyc <= 0;
            lines <= 0;
        end else if (cyc == PER - 1) begin
            cyc <= 0;
            lines <= lines + 1;
        end else begin
            cyc <= cyc + 1;
        end
    end

    // Pins rest at the inactive level whenever the source is stopped
    assign line_o = pol_i ~^ (run_i && cyc < WID);
    assign frame_o = pol_i ~^ (run_i && lines == 0);
endmodule : sicond_src_model

// ==== verification/sicond_checker.sv ====
// Port-level assertions for the sync input conditioning block.
module sicond_checker #(
    parameter int CLAMP_W = 8,
    parameter int COAST_W = 8
) (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic line_sync_in_a_i,
    input wire logic green_embedded_sync_in_a_i,
    input wire logic input_set_sel_i,
    input wire logic line_src_sel_i,
    input wire logic [1:0] line_pol_ctrl_i,
    input wire logic [1:0] frame_pol_ctrl_i,
    input wire logic [sicond_pkg::SLICE_CODE_W-1:0] slice_code_i,
    input wire logic slice_code_wr_i,
    input wire logic ext_clamp_en_i,
    input wire logic [CLAMP_W-1:0] clamp_width_i,
    input wire logic [COAST_W-1:0] coast_post_lines_i,
    input wire logic line_ref_pulse_o,
    input wire logic line_sync_o,
    input wire logic frame_sync_o,
    input wire logic line_pol_o,
    input wire logic frame_pol_o,
    input wire logic coast_o,
    input wire logic clamp_o,
    input wire logic slicer_sync_out_o,
    input wire logic [sicond_pkg::SLICE_CODE_W-1:0] slice_code_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);

    property p_ref_lead;
        line_ref_pulse_o |-> $rose(line_sync_o);
    endproperty
    a_ref_lead: assert property (p_ref_lead)
        else $error("leading pulse without rise of line sync");

    property p_pin_lat;
        !line_src_sel_i && !input_set_sel_i && line_pol_ctrl_i == 2'h3 &&
            $rose(line_sync_in_a_i) |-> ##[3:4] line_ref_pulse_o;
    endproperty
    a_pin_lat: assert property (p_pin_lat)
        else $error("line pin rise gave no leading pulse in time");

    property p_line_pol;
        (line_pol_ctrl_i[1] && $stable(line_pol_ctrl_i)) [*4] |->
            line_pol_o == line_pol_ctrl_i[0];
    endproperty
    a_line_pol: assert property (p_line_pol)
        else $error("forced line polarity not applied");

    property p_frame_pol;
        (frame_pol_ctrl_i[1] && $stable(frame_pol_ctrl_i)) [*4] |->
            frame_pol_o == frame_pol_ctrl_i[0];
    endproperty
    a_frame_pol: assert property (p_frame_pol)
        else $error("forced frame polarity not applied");

    property p_slicer;
        (!input_set_sel_i && $stable(green_embedded_sync_in_a_i)) [*4] |->
            slicer_sync_out_o == green_embedded_sync_in_a_i;
    endproperty
    a_slicer: assert property (p_slicer)
        else $error("slicer output differs from selected input");

    property p_code;
        slice_code_wr_i |=> slice_code_o == $past(slice_code_i);
    endproperty
    a_code: assert property (p_code)
        else $error("threshold code not taken");

    property p_coast;
        $fell(frame_sync_o) |-> coast_o == (coast_post_lines_i != '0);
    endproperty
    a_coast: assert property (p_coast)
        else $error("coast wrong as frame sync ends");

    property p_clamp_off;
        (!ext_clamp_en_i && clamp_width_i == '0) [*4] |-> !clamp_o;
    endproperty
    a_clamp_off: assert property (p_clamp_off)
        else $error("clamp raised with zero width");
endmodule : sicond_checker

bind sicond_top sicond_checker #(.CLAMP_W(CLAMP_W), .COAST_W(COAST_W))
    u_chk (
    .sys_clk_i, .reset_i, .line_sync_in_a_i, .green_embedded_sync_in_a_i,
    .input_set_sel_i, .line_src_sel_i, .line_pol_ctrl_i, .frame_pol_ctrl_i,
    .slice_code_i, .slice_code_wr_i, .ext_clamp_en_i, .clamp_width_i,
    .coast_post_lines_i,
    .line_ref_pulse_o, .line_sync_o, .frame_sync_o, .line_pol_o,
    .frame_pol_o, .coast_o, .clamp_o, .slicer_sync_out_o, .slice_code_o);

// ==== verification/sicond_test.sv ====
// Self-checking bench for the sync input conditioning block.
module sicond_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk_i, reset_i, line_sync_in_a_i, line_sync_in_b_i, run, pol;
    logic frame_sync_in_a_i, frame_sync_in_b_i, ext_clamp_i, ext_clamp_en_i;
    logic green_embedded_sync_in_a_i, green_embedded_sync_in_b_i;
    logic input_set_sel_i, line_src_sel_i, slice_code_wr_i;
    logic [1:0] line_pol_ctrl_i, frame_pol_ctrl_i;
    logic [7:0] clamp_delay_i, clamp_width_i, coast_post_lines_i;
    logic line_ref_pulse_o, line_trail_pulse_o, line_sync_o, frame_sync_o;
    logic line_pol_o, frame_pol_o, field_odd_o, coast_o, clamp_o;
    logic slicer_sync_out_o;
    logic [sicond_pkg::SLICE_CODE_W-1:0] slice_code_i, slice_code_o;
    int n_mismatch, n_compared, n_ref, n_trail, n_clamp, n_cyc;

    sicond_src_model src (.clk_i(sys_clk_i), .run_i(run), .pol_i(pol),
        .line_o(line_sync_in_a_i), .frame_o(frame_sync_in_a_i));
    sicond_top #(.LINE_HOLDOFF(8), .BROAD_PULSE(16)) dut (.sys_clk_i,
        .reset_i, .line_sync_in_a_i, .line_sync_in_b_i, .frame_sync_in_a_i,
        .frame_sync_in_b_i, .green_embedded_sync_in_a_i,
        .green_embedded_sync_in_b_i, .ext_clamp_i, .input_set_sel_i,
        .line_src_sel_i, .line_pol_ctrl_i, .frame_pol_ctrl_i, .slice_code_i,
        .slice_code_wr_i, .ext_clamp_en_i, .clamp_delay_i, .clamp_width_i,
        .coast_post_lines_i, .line_ref_pulse_o, .line_trail_pulse_o,
        .line_sync_o, .frame_sync_o, .line_pol_o, .frame_pol_o, .field_odd_o,
        .coast_o, .clamp_o, .slicer_sync_out_o, .slice_code_o);

    // Free-running 125 MHz clock
    initial begin
        sys_clk_i = 1'b0;
        forever #4 sys_clk_i = ~sys_clk_i;
    end

    task automatic report_and_stop;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : report_and_stop

    // Counters only ever grow, so tests take differences and never race
    always @(posedge sys_clk_i) begin
        n_cyc++;
        if (line_ref_pulse_o === 1'b1) n_ref++;
        if (line_trail_pulse_o === 1'b1) n_trail++;
        if (clamp_o === 1'b1) n_clamp++;
        if (n_cyc == 4000) begin
            n_mismatch++;
            report_and_stop();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask : tick

    // Run the source for whole lines, then let the pipeline drain
    task automatic lines(input int n);
        run <= 1'b1;
        tick(n * 40);
        run <= 1'b0;
        tick(12);
    endtask : lines

    task automatic gpulse(input int hi, input int lo);
        green_embedded_sync_in_a_i <= 1'b1;
        tick(hi);
        green_embedded_sync_in_a_i <= 1'b0;
        tick(lo);
    endtask : gpulse

    function automatic logic [7:0] b8(input logic x);
        return {7'h00, x};
    endfunction : b8

    function automatic logic exp_slice(input logic s, a, b);
        return s ? b : a;
    endfunction : exp_slice

    initial begin
        logic [4:0] code;
        logic s, ga, gb;
        int b0, b1, w;
        void'($urandom(32'h7ee8));
        {reset_i, pol, line_sync_in_b_i, frame_sync_in_b_i} = 4'h9;
        {run, ext_clamp_i, ext_clamp_en_i, input_set_sel_i} = 4'h0;
        {line_src_sel_i, slice_code_wr_i} = 2'h0;
        {green_embedded_sync_in_a_i, green_embedded_sync_in_b_i} = 2'h0;
        {line_pol_ctrl_i, frame_pol_ctrl_i} = 4'hf;
        slice_code_i = 5'h00;
        {clamp_delay_i, clamp_width_i} = 16'h0204;
        coast_post_lines_i = 8'($urandom % 4);
        tick(3);
        reset_i <= 1'b0;
        tick(1);
        check(b8(clamp_o), 8'h00);
        check(8'(slice_code_o), 8'h0f);
        // Threshold codes: both ends of the range, then random ones
        for (int i = 0; i < 8; i++) begin
            code = (i == 0) ? 5'h00 : (i == 1) ? 5'h1f : 5'($urandom);
            slice_code_i <= code;
            slice_code_wr_i <= 1'b1;
            tick(1);
            slice_code_wr_i <= 1'b0;
            slice_code_i <= ~code;
            tick(2);
            check(8'(slice_code_o), 8'(code));
        end
        $display("threshold test done");
        // Each polarity forced, then line polarity detected; edges counted when forced
        for (int p = 0; p < 2; p++) begin
            for (int m = 0; m < 2; m++) begin
                pol <= p[0];
                line_pol_ctrl_i <= m ? 2'h0 : {1'b1, p[0]};
                frame_pol_ctrl_i <= {1'b1, p[0]};
                tick(10);
                b0 = n_ref;
                b1 = n_trail;
                lines(3);
                check(b8(line_pol_o), b8(p[0]));
                check(b8(frame_pol_o), b8(p[0]));
                if (m == 0) check(8'(n_ref - b0), 8'h03);
                if (m == 0) check(8'(n_trail - b1), 8'h03);
                // Frame lead meets a line lead; two later leads use coast up
                if (m == 0) begin
                    check(b8(coast_o), b8(coast_post_lines_i > 2));
                    check(b8(field_odd_o), 8'h01);
                    check({6'h00, line_sync_o, frame_sync_o}, 8'h00);
                end
            end
        end
        $display("polarity test done");
        // Set B idle while set A runs, then one pulse on set B
        line_pol_ctrl_i <= 2'h3;
        input_set_sel_i <= 1'b1;
        tick(10);
        b0 = n_ref;
        lines(2);
        check(8'(n_ref - b0), 8'h00);
        line_sync_in_b_i <= 1'b1;
        tick(3);
        line_sync_in_b_i <= 1'b0;
        tick(10);
        check(8'(n_ref - b0), 8'h01);
        $display("select test done");
        for (int i = 0; i < 8; i++) begin
            {s, ga, gb} = 3'($urandom);
            input_set_sel_i <= s;
            green_embedded_sync_in_a_i <= ga;
            green_embedded_sync_in_b_i <= gb;
            tick(6);
            check(b8(slicer_sync_out_o), b8(exp_slice(s, ga, gb)));
        end
        $display("slicer test done");
        input_set_sel_i <= 1'b0;
        green_embedded_sync_in_a_i <= 1'b0;
        // Internal clamp: zero width first, then random delay and width
        for (int i = 0; i < 3; i++) begin
            w = (i == 0) ? 0 : 1 + ($urandom % 8);
            clamp_delay_i <= 8'(1 + $urandom % 8);
            clamp_width_i <= 8'(w);
            tick(8);
            b0 = n_clamp;
            lines(1);
            check(8'(n_clamp - b0), 8'(w));
        end
        ext_clamp_en_i <= 1'b1;
        ext_clamp_i <= 1'b1;
        tick(6);
        check(b8(clamp_o), 8'h01);
        ext_clamp_i <= 1'b0;
        tick(6);
        check(b8(clamp_o), 8'h00);
        ext_clamp_en_i <= 1'b0;
        $display("clamp test done");
        // Composite from the slicer: a lead inside the holdoff is dropped
        line_src_sel_i <= 1'b1;
        tick(10);
        b0 = n_ref;
        gpulse(2, 3);
        gpulse(2, 40);
        gpulse(2, 20);
        check(8'(n_ref - b0), 8'h02);
        $display("composite test done");
        report_and_stop();
    end
endmodule : sicond_test
